// [shared/hv_link_params.svh]
// offsets, field positions, codes and timing counts of the die control link
`ifndef HV_LINK_PARAMS_SVH
`define HV_LINK_PARAMS_SVH
`define OFS_COMMAND 5'h04
`define OFS_DATA 5'h0C
`define OFS_CFG 5'h10
`define OFS_STA 5'h18
`define CMD_READ_CFG 8'h00
`define CMD_READ_STA 8'h02
`define CMD_WRITE_CFG 8'h08
`define BIT_BUSY 0
`define BIT_PARITY 1
`define BIT_ACK 2
`define BIT_MIRROR 3
`define CFG_MASK 8'h1F
`define STA_MASK 8'h07
`define RST_CFG 8'h00
`define RST_STA 8'h00
`define RST_DATA 8'h00
`define LINK_DIV 8
`define FRAME_BITS 14
`define CMD_BITS 4
`define DATA_END 12
`endif

// [shared/hv_link_pkg.sv]
// types shared by the die control link modules
package hv_link_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_KEYHOLE = 3'b001,
    SEQ_MIRROR_WR = 3'b010,
    SEQ_MIRROR_RD = 3'b011,
    SEQ_IRQ_RD = 3'b100
  } seq_state_type;
  typedef struct packed {
    logic [3:0] command;
    logic [7:0] data;
  } link_request_type;
  typedef struct packed {
    logic [7:0] data;
    logic parity_ok;
    logic ack;
  } link_result_type;
endpackage

// [design/pin_sync.sv]
// three-stage synchroniser for a pin from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level
);
  logic s1, s2, s3;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// [design/link_shifter.sv]
// serial engine: divided link clock, frame shift out and shift in
`timescale 1ns/1ps
`default_nettype none
`include "hv_link_params.svh"
module link_shifter import hv_link_pkg::*; #(
  parameter int DIV = `LINK_DIV
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic is_read,
  input wire link_request_type request,
  input wire logic data_in,
  output link_result_type result,
  output logic done,
  output logic busy,
  output logic [7:0] shift_byte,
  output logic die_link_clock,
  output logic die_data_out,
  output logic die_data_oe
);
  // the slave's bit needs four sync cycles before the sampling phase
  if (DIV < 8 || DIV % 2 != 0) begin : g_bad_div
    $error("link divider must be even and at least 8");
  end
  localparam int CW = $clog2(DIV);
  localparam int BW = $clog2(`FRAME_BITS);
  logic [CW-1:0] phase;
  logic [BW-1:0] bit_index;
  logic [BW-1:0] next_index;
  logic [13:0] tx;
  logic rd, par_rx, bit_end, last, take;
  assign take = start && !busy;
  assign bit_end = busy && (phase == CW'(DIV - 1));
  assign last = bit_index == BW'(`FRAME_BITS - 1);
  assign next_index = bit_index + BW'(1);
  assign die_data_out = tx[13];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      phase <= '0;
      bit_index <= '0;
      rd <= 1'b0;
    end else begin
      done <= bit_end && last;
      phase <= (take || bit_end) ? '0 : phase + CW'(1);
      if (take) begin
        busy <= 1'b1;
        bit_index <= '0;
        rd <= is_read;
      end else if (bit_end) begin
        busy <= !last;
        bit_index <= next_index;
      end
    end
  end
  // -------------------------------------------------------------------
  // pins: clock high in the second half of each bit time, data set at start
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx <= '0;
      die_data_oe <= 1'b0;
      die_link_clock <= 1'b0;
    end else begin
      die_link_clock <= busy && !bit_end && (phase >= CW'(DIV / 2 - 1)); // see R02
      if (take) begin
        tx <= {request.command, request.data, ^request.data, 1'b0}; // see R23
        die_data_oe <= 1'b1;
      end else if (bit_end) begin
        tx <= {tx[12:0], 1'b0};
        die_data_oe <= !last && (next_index < BW'(`CMD_BITS)
          || (!rd && next_index < BW'(`FRAME_BITS - 1))); // see R01
      end
    end
  end
  // -------------------------------------------------------------------
  // shift register: rotates out on writes, shifts in on reads
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_byte <= '0;
      par_rx <= 1'b0;
      result <= '0;
    end else if (take) begin
      shift_byte <= request.data;
    end else if (bit_end) begin
      if (bit_index >= BW'(`CMD_BITS) && bit_index < BW'(`DATA_END)) begin
        shift_byte <= {shift_byte[6:0], rd ? data_in : shift_byte[7]}; // see R16
      end
      if (bit_index == BW'(`DATA_END)) begin
        par_rx <= data_in;
      end
      if (last) begin
        result.data <= shift_byte;
        result.parity_ok <= !rd || (^shift_byte == par_rx); // see R13
        result.ack <= data_in; // see R12
      end
    end
  end
endmodule // link_shifter
`default_nettype wire

// [design/hv_die_control_link.sv]
// master end of the three-wire control link to the high-voltage companion die
// Contract
// (R01) three wires: link clock, two-way data, interrupt; this die is master.
// (R02) link clock runs at one eighth of the system clock.
// (R03) keyhole read result lands in the low byte of keyhole data.
// (R04) software loads keyhole data first, then writes the write command.
// (R05) remote interrupt copies remote status into keyhole data automatically.
// (R06) writing the config shadow launches a link write of that value.
// (R07) after a mirrored write the config shadow takes the read-back value.
// (R08) status shadow changes only on interrupt or keyhole status read.
// (R09) software waits 20 us after mirrored writes, or polls.
// (R10) command codes: 0x00 read config, 0x02 read status, 0x08 write config.
// (R11) command bit 3 shows a mirrored write pending; no keyhole writes then.
// (R12) command bit 2 shows slave acknowledge of the last transfer.
// (R13) command bit 1 shows receive parity match of the last transfer.
// (R14) command bit 0 shows a transfer busy; no new command until clear.
// (R15) keyhole data bits 11..8 show the last command written.
// (R16) keyhole data bits 7..0 show the link shift register.
// (R17) config byte: flag enable 4, diagnostic 3, transceiver 0; 7..5 reserved.
// (R18) remote hardware clears the driver re-enable bit 2 itself.
// (R19) protect-disable bit 1 keeps short event but no driver shutdown.
// (R20) status bit 2 shows supply above limit, valid with flag enable.
// (R21) status bit 1 follows the live short detector.
// (R22) status bit 0 records a bus short event; bus then disabled.
// (R23) each transfer: command, eight data bits, parity, slave acknowledge.
// (R24) command and shadow writes arriving while busy are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "hv_link_params.svh"
module hv_die_control_link import hv_link_pkg::*; #(
  parameter int DIV = `LINK_DIV
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic die_link_clock,
  output logic die_data_out,
  output logic die_data_oe,
  input wire logic die_data_in,
  input wire logic die_interrupt_line
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  seq_state_type state;
  link_request_type request;
  link_result_type result;
  logic link_start, link_rd, link_done, link_busy;
  logic [7:0] shift_byte;
  logic data_sync, irq_sync, irq_prev, irq_rise, irq_pending;
  logic [3:0] last_command_field;
  logic [7:0] keyhole_byte, config_shadow, status_shadow;
  logic parity_ok, ack_result;
  logic wr_take, cmd_take, cfg_take, data_take, cmd_valid, irq_launch;
  logic status_read, sta_load, seq_busy, mirror_write_pending;
  logic [7:0] wbyte;
  logic [31:0] next_readdata;
  // -------------------------------------------------------------------
  // pin inputs
  // -------------------------------------------------------------------
  pin_sync u_data_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(die_data_in),
    .level(data_sync)
  );
  pin_sync u_irq_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(die_interrupt_line),
    .level(irq_sync)
  );
  link_shifter #(
    .DIV(DIV)
  ) u_shifter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(link_start),
    .is_read(link_rd),
    .request(request),
    .data_in(data_sync),
    .result(result),
    .done(link_done),
    .busy(link_busy),
    .shift_byte(shift_byte),
    .die_link_clock(die_link_clock),
    .die_data_out(die_data_out),
    .die_data_oe(die_data_oe)
  );
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= irq_sync;
    end
  end
  assign irq_rise = irq_sync && !irq_prev;
  // -------------------------------------------------------------------
  // bus slave: one wait cycle, then the access is taken
  // -------------------------------------------------------------------
  assign wbyte = avs_writedata[7:0];
  assign seq_busy = state != SEQ_IDLE;
  assign mirror_write_pending = state == SEQ_MIRROR_WR || state == SEQ_MIRROR_RD;
  assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign cmd_take = wr_take && avs_address == `OFS_COMMAND && !seq_busy; // see R24
  assign cfg_take = wr_take && avs_address == `OFS_CFG && !seq_busy; // see R24
  assign data_take = wr_take && avs_address == `OFS_DATA && !seq_busy;
  assign cmd_valid = wbyte == `CMD_READ_CFG || wbyte == `CMD_READ_STA
    || wbyte == `CMD_WRITE_CFG; // see R10
  assign irq_launch = state == SEQ_IDLE && irq_pending && !cmd_take && !cfg_take;
  assign status_read = last_command_field == 4'(`CMD_READ_STA);
  assign sta_load = link_done && (state == SEQ_IRQ_RD
    || (state == SEQ_KEYHOLE && status_read));
  always_comb begin
    next_readdata = '0;
    case (avs_address)
      `OFS_COMMAND: begin
        next_readdata[`BIT_MIRROR] = mirror_write_pending; // see R11
        next_readdata[`BIT_ACK] = ack_result; // see R12
        next_readdata[`BIT_PARITY] = parity_ok; // see R13
        next_readdata[`BIT_BUSY] = seq_busy; // see R14
      end
      `OFS_DATA: begin
        next_readdata[11:8] = last_command_field; // see R15
        next_readdata[7:0] = link_busy ? shift_byte : keyhole_byte; // see R16
      end
      `OFS_CFG: next_readdata[7:0] = config_shadow;
      `OFS_STA: next_readdata[7:0] = status_shadow;
      default: next_readdata = '0;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end
    end
  end
  // -------------------------------------------------------------------
  // transfer sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SEQ_IDLE;
      link_start <= 1'b0;
      link_rd <= 1'b0;
      request <= '0;
    end else begin
      link_start <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          if (cmd_take && cmd_valid) begin
            state <= SEQ_KEYHOLE;
            link_start <= 1'b1;
            link_rd <= wbyte != `CMD_WRITE_CFG;
            // write sends what software left in keyhole data beforehand
            request <= {wbyte[3:0], keyhole_byte}; // see R04
          end else if (cfg_take) begin
            state <= SEQ_MIRROR_WR;
            link_start <= 1'b1;
            link_rd <= 1'b0;
            request.command <= 4'(`CMD_WRITE_CFG);
            request.data <= wbyte & `CFG_MASK; // see R06
          end else if (irq_launch) begin
            // a command or config write in the same cycle goes first; the irq waits until the sequencer is back in idle
            state <= SEQ_IRQ_RD;
            link_start <= 1'b1;
            link_rd <= 1'b1;
            request.command <= 4'(`CMD_READ_STA); // see R05
            request.data <= 8'h00;
          end
        end
        SEQ_MIRROR_WR: begin
          if (link_done) begin
            state <= SEQ_MIRROR_RD;
            link_start <= 1'b1;
            link_rd <= 1'b1;
            request.command <= 4'h0;
            request.data <= 8'h00;
          end
        end
        SEQ_KEYHOLE, SEQ_MIRROR_RD, SEQ_IRQ_RD: begin
          if (link_done) begin
            state <= SEQ_IDLE;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end
  // -------------------------------------------------------------------
  // interrupt request: an edge in the launch cycle is kept
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pending <= 1'b0;
    end else if (irq_rise) begin
      irq_pending <= 1'b1;
    end else if (irq_launch) begin
      irq_pending <= 1'b0;
    end
  end
  // -------------------------------------------------------------------
  // software-visible registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      last_command_field <= '0;
      keyhole_byte <= `RST_DATA;
      parity_ok <= 1'b0;
      ack_result <= 1'b0;
    end else begin
      if (cmd_take) begin
        last_command_field <= wbyte[3:0]; // see R15
      end
      if (data_take) begin
        keyhole_byte <= wbyte;
      end else if (link_done && (state == SEQ_KEYHOLE || state == SEQ_IRQ_RD)) begin
        keyhole_byte <= result.data; // see R03 see R05
      end
      if (link_done) begin
        parity_ok <= result.parity_ok; // see R13
        ack_result <= result.ack; // see R12
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      config_shadow <= `RST_CFG;
      status_shadow <= `RST_STA;
    end else begin
      // reserved bits never stored; remote clears re-enable itself
      if (cfg_take) begin
        config_shadow <= wbyte & `CFG_MASK; // see R17 see R19
      end else if (link_done && state == SEQ_MIRROR_RD) begin
        config_shadow <= result.data & `CFG_MASK; // see R07 see R18
      end
      if (sta_load) begin
        status_shadow <= result.data & `STA_MASK; // see R08 see R20 see R21 see R22
      end
    end
  end
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_link_clock_half: assert property ($rose(die_link_clock) // see R02
    |-> die_link_clock[*4] ##1 !die_link_clock)
    else $error("link clock high phase wrong");
  a_pin_drive_frame: assert property (die_data_oe |-> link_busy) // see R01
    else $error("data pin driven outside a frame");
  // plain delay holds for the default divider of eight only
  a_frame_length: assert property ($rose(link_busy) |-> ##112 link_done) // see R23
    else $error("frame length wrong");
  a_keyhole_read: assert property (link_done && state == SEQ_KEYHOLE && link_rd // see R03
    |=> keyhole_byte == $past(result.data))
    else $error("read byte lost");
  a_irq_copy: assert property (irq_rise && state == SEQ_IDLE // see R05
    && !cmd_take && !cfg_take |-> ##[1:130] (link_done && state == SEQ_IRQ_RD))
    else $error("irq not served");
  a_mirror_launch: assert property (cfg_take // see R06
    |=> state == SEQ_MIRROR_WR ##1 link_busy)
    else $error("mirror write not launched");
  a_mirror_refresh: assert property (link_done && state == SEQ_MIRROR_RD // see R07
    |=> config_shadow == ($past(result.data) & `CFG_MASK) && state == SEQ_IDLE)
    else $error("config shadow not refreshed");
  a_status_hold: assert property (!sta_load |=> $stable(status_shadow)) // see R08
    else $error("status shadow changed");
  a_reserved_cmd: assert property (cmd_take && !cmd_valid |=> state == SEQ_IDLE) // see R10
    else $error("reserved code started");
  // a frame end may refresh the shadow while a write is refused
  a_busy_ignore: assert property (wr_take && seq_busy && !link_done // see R24
    |=> $stable(last_command_field) && $stable(config_shadow))
    else $error("write taken while busy");
  a_ack_report: assert property (link_done // see R12
    |=> ack_result == $past(result.ack))
    else $error("ack bit not reported");
  a_parity_report: assert property (link_done // see R13
    |=> parity_ok == $past(result.parity_ok))
    else $error("parity bit not reported");
  a_busy_report: assert property (avs_read && avs_waitrequest // see R14
    && avs_address == `OFS_COMMAND |=> avs_readdata[`BIT_BUSY] == $past(seq_busy))
    else $error("busy bit not reported");
  a_write_source: assert property (link_start && state == SEQ_KEYHOLE // see R04
    && !link_rd |-> request.data == keyhole_byte)
    else $error("keyhole write byte wrong");
  a_data_load: assert property (data_take // see R04
    |=> keyhole_byte == $past(wbyte))
    else $error("keyhole byte not stored");
  a_status_load: assert property (sta_load // see R08
    |=> status_shadow == ($past(result.data) & `STA_MASK))
    else $error("status shadow not loaded");
  a_cfg_reserved: assert property (config_shadow[7:5] == 3'h0) // see R17
    else $error("reserved config bits set");
  a_sta_reserved: assert property (status_shadow[7:3] == 5'h00) // see R08
    else $error("reserved status bits set");
  // the slave always answers after exactly one wait cycle
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer late");
  a_irq_set_wins: assert property (irq_rise // see R05
    |=> irq_pending)
    else $error("irq edge lost");
  a_start_idle: assert property (link_start // see R24
    |-> !link_busy)
    else $error("frame started over a busy link");
  a_clock_idle: assert property (!link_busy // see R02
    |-> !die_link_clock)
    else $error("link clock runs outside a frame");
  a_upper_zero: assert property (avs_readdata[31:12] == 20'h00000) // see R15
    else $error("unused read bits set");
  // mirror bound: two frames and gaps; a hang here would stall software
  localparam int MIRROR_MAX = 2 * (`FRAME_BITS * DIV + 4);
  logic [15:0] mirror_cycles;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mirror_cycles <= '0;
    end else if (mirror_write_pending) begin
      mirror_cycles <= mirror_cycles + 16'h0001;
    end else begin
      mirror_cycles <= '0;
    end
  end
  a_mirror_bound: assert property (mirror_cycles <= 16'(MIRROR_MAX)) // see R11
    else $error("mirrored write never ends");
  c_keyhole_read: cover property (link_done && state == SEQ_KEYHOLE && link_rd);
  c_keyhole_write: cover property (link_done && state == SEQ_KEYHOLE && !link_rd);
  c_mirror_done: cover property (link_done && state == SEQ_MIRROR_RD);
  c_irq_read: cover property (link_done && state == SEQ_IRQ_RD);
  c_nack_seen: cover property (link_done && !result.ack);
endmodule // hv_die_control_link
`default_nettype wire

// [bench/hv_die_model.sv]
// behavioural model of the high-voltage companion die at the far end of the link
`timescale 1ns/1ps
`default_nettype none
module hv_die_model (
  input wire logic sys_rst,
  input wire logic link_clock,
  input wire logic data_wire,
  input wire logic short_in,
  input wire logic supply_ok,
  input wire logic nack,
  input wire logic bad_parity,
  output logic data_out,
  output logic data_oe,
  output logic irq,
  output logic [7:0] cfg,
  output logic [7:0] sta
);
  int bit_n;
  logic [12:0] rx;
  logic [3:0] cmd;
  logic [7:0] rd;
  logic short_event;
  // ----------------------------------------
  // status and interrupt
  // ----------------------------------------
  always @(posedge short_in or posedge sys_rst) begin
    short_event <= !sys_rst;
  end
  assign sta = {5'h00, supply_ok & cfg[4], short_in, short_event};
  assign irq = short_event;
  // ----------------------------------------
  // frame receive: bits counted on clock rises, whole frames only
  // ----------------------------------------
  always @(posedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_n <= 0;
      rx = 13'h0000;
      cmd <= 4'h0;
      cfg <= 8'h00;
    end else begin
      rx = {rx[11:0], data_wire};
      if (bit_n == 3) cmd <= rx[3:0];
      // reserved bits dropped, driver re-enable clears itself at once
      if (bit_n == 12 && cmd == 4'h8) cfg <= rx[8:1] & 8'h1B;
      bit_n <= (bit_n == 13) ? 0 : bit_n + 1;
    end
  end
  // ----------------------------------------
  // frame transmit: change on falling edge, master samples before the next one
  // ----------------------------------------
  always @(negedge link_clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_oe <= 1'b0;
      data_out <= 1'b0;
    end else begin
      if (bit_n == 4) rd = (cmd == 4'h2) ? sta : cfg;
      data_oe <= (bit_n == 13) || (!cmd[3] && bit_n >= 4 && bit_n <= 12);
      if (bit_n == 13) data_out <= !nack;
      else if (bit_n == 12) data_out <= (^rd) ^ bad_parity;
      else if (bit_n >= 4) data_out <= rd[11 - bit_n];
    end
  end
endmodule // hv_die_model
`default_nettype wire

// [bench/hv_die_control_link_bench.sv]
// self-checking bench of the die control link master
`timescale 1ns/1ps
`default_nettype none
`include "hv_link_params.svh"
module hv_die_control_link_bench;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic link_clk, d_out, d_oe, m_out, m_oe, irq, lvl, last_lvl, line;
  logic short_in, supply_ok, nack, bad_parity;
  logic [7:0] rcfg, rsta, v;
  int bad_count, n_tests, rises;
  time t_last;
  hv_die_control_link #(.DIV(`LINK_DIV)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .die_link_clock(link_clk), .die_data_out(d_out), .die_data_oe(d_oe),
    .die_data_in(line), .die_interrupt_line(irq));
  hv_die_model model (.sys_rst(sys_rst), .link_clock(link_clk), .data_wire(line),
    .short_in(short_in), .supply_ok(supply_ok), .nack(nack), .bad_parity(bad_parity),
    .data_out(m_out), .data_oe(m_oe), .irq(irq), .cfg(rcfg), .sta(rsta));
  // an undriven wire shows the inverse of its last level, never a stale match
  assign lvl = d_oe ? d_out : m_out;
  assign line = (d_oe || m_oe) ? lvl : !last_lvl;
  always @(posedge clk_sys) if (d_oe || m_oe) last_lvl <= lvl;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = !clk_sys;
  end
  // ----------------------------------------
  // compare and verdict
  // ----------------------------------------
  task check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask
  task check_time(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: period got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // bus master and helpers
  // ----------------------------------------
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) begin
      bad_count++;
      $display("Error at %0t: no answer %h %h", $time, a, wd);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, `OFS_COMMAND, 32'h0, rd);
      n++;
    end while ((rd[0] !== 1'b0 || rd[3] !== 1'b0) && n < 200);
    if (n >= 200) begin
      bad_count++;
      $display("Error at %0t: still busy %h %h", $time, rd, 32'h0);
    end
  endtask
  function logic [31:0] exp_cfg(input logic [7:0] x);
    return {24'h0, x & 8'h1B};
  endfunction
  function logic [31:0] exp_sta(input logic sh, input logic ev, input logic sup, input logic [7:0] c);
    return {29'h0, sup & c[4], sh, ev};
  endfunction
  // link clock is sys/8 inside frames; gaps between frames are not bit times
  always @(posedge link_clk) begin
    if (rises % 14 != 0) check_time(32'($time - t_last), 32'(`LINK_DIV * 100));
    t_last = $time;
    rises++;
  end
  initial begin
    #3000000;
    $display("Error at %0t: watchdog expired", $time);
    bad_count++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {short_in, supply_ok, nack, bad_parity, last_lvl} = '0;
    avs_byteenable = 4'hF;
    bad_count = 0;
    n_tests = 0;
    rises = 0;
    t_last = 0;
    sys_rst = 1'b1;
    void'($urandom(84));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0, rd);
      check_reg(rd, 32'h0);
    end
    bus(1'b1, `OFS_STA, 32'hFF, rd);
    bus(1'b0, `OFS_STA, 32'h0, rd);
    check_reg(rd, 32'h0);
    bus(1'b1, `OFS_COMMAND, 32'h05, rd);
    bus(1'b0, `OFS_COMMAND, 32'h0, rd);
    check_reg(rd, 32'h0);
    bus(1'b0, `OFS_DATA, 32'h0, rd);
    check_reg(rd, 32'h500);
    avs_byteenable <= 4'hE;
    bus(1'b1, `OFS_DATA, 32'h33, rd);
    avs_byteenable <= 4'hF;
    bus(1'b0, `OFS_DATA, 32'h0, rd);
    check_reg(rd, 32'h500);
    bus(1'b1, `OFS_DATA, 32'h1D, rd);
    bus(1'b1, `OFS_COMMAND, 32'h08, rd);
    bus(1'b0, `OFS_COMMAND, 32'h0, rd);
    check_reg(rd, 32'h1);
    bus(1'b1, `OFS_DATA, 32'hAA, rd);
    bus(1'b1, `OFS_CFG, 32'h01, rd);
    bus(1'b1, `OFS_COMMAND, 32'h02, rd);
    wait_idle;
    check_reg(rd, 32'h6);
    bus(1'b0, `OFS_DATA, 32'h0, rd);
    check_reg(rd, 32'h81D);
    check_reg({24'h0, rcfg}, exp_cfg(8'h1D));
    bus(1'b1, `OFS_COMMAND, 32'h00, rd);
    wait_idle;
    bus(1'b0, `OFS_DATA, 32'h0, rd);
    check_reg(rd, exp_cfg(8'h1D));
    nack <= 1'b1;
    bad_parity <= 1'b1;
    bus(1'b1, `OFS_COMMAND, 32'h00, rd);
    wait_idle;
    check_reg(rd, 32'h0);
    nack <= 1'b0;
    bad_parity <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      supply_ok <= 1'($urandom);
      bus(1'b1, `OFS_CFG, {24'h0, v}, rd);
      bus(1'b0, `OFS_COMMAND, 32'h0, rd);
      check_reg({31'h0, rd[3]}, 32'h1);
      wait_idle;
      check_reg({24'h0, rcfg}, exp_cfg(v));
      bus(1'b0, `OFS_CFG, 32'h0, rd);
      check_reg(rd, exp_cfg(v));
      bus(1'b1, `OFS_COMMAND, 32'h02, rd);
      wait_idle;
      bus(1'b0, `OFS_STA, 32'h0, rd);
      check_reg(rd, exp_sta(1'b0, 1'b0, supply_ok, v));
      bus(1'b0, `OFS_DATA, 32'h0, rd);
      check_reg(rd, 32'h200 | exp_sta(1'b0, 1'b0, supply_ok, v));
    end
    short_in <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wait_idle;
    bus(1'b0, `OFS_STA, 32'h0, rd);
    check_reg(rd, exp_sta(1'b1, 1'b1, supply_ok, v));
    bus(1'b0, `OFS_DATA, 32'h0, rd);
    check_reg(rd, 32'h200 | exp_sta(1'b1, 1'b1, supply_ok, v));
    short_in <= 1'b0;
    bus(1'b1, `OFS_COMMAND, 32'h00, rd);
    wait_idle;
    bus(1'b0, `OFS_STA, 32'h0, rd);
    check_reg(rd, exp_sta(1'b1, 1'b1, supply_ok, v));
    print_verdict;
  end
endmodule // hv_die_control_link_bench
`default_nettype wire
